// file: include/fpb_pkg.sv
`default_nettype none
package fpb_pkg;
    localparam int FPB_NUM_FIFOS = 5;
    localparam int FPB_HOST_AW = 8;
    localparam int FPB_PTR_W = 16;
    localparam logic [7:0] FPB_PTR_OFS = 8'hF8;
    localparam logic [7:0] FPB_DATA_OFS = 8'hFC;
    localparam logic [15:0] FPB_QUAD_STEP = 16'h0004;
    localparam logic [15:0] FPB_ARQ_OFS = 16'h0104;
    localparam logic [15:0] FPB_ATS_OFS = 16'h0110;
    localparam logic [15:0] FPB_ATQ_OFS = 16'h0114;
    localparam logic [15:0] FPB_IRX_OFS = 16'h0120;
    localparam logic [15:0] FPB_ITX_OFS = 16'h0130;
    localparam logic [31:0] FPB_ARQ_RST = 32'h00000407;
    localparam logic [31:0] FPB_ATS_RST = 32'h0000080B;
    localparam logic [31:0] FPB_ATQ_RST = 32'h00000C0F;
    localparam logic [31:0] FPB_IRX_RST = 32'h0000101F;
    localparam logic [31:0] FPB_ITX_RST = 32'h0000202F;
    localparam int FPB_START_LSB = 8;
    localparam int FPB_START_MSB = 13;
    localparam int FPB_END_LSB = 0;
    localparam int FPB_END_MSB = 5;
    localparam logic [5:0] FPB_LOW_ZEROS = 6'h00;
    localparam logic [5:0] FPB_LOW_ONES = 6'h3F;
    localparam logic [6:0] FPB_ONE_BLOCK = 7'h01;
    localparam logic [4:0][15:0] FPB_OFS = {FPB_ITX_OFS, FPB_IRX_OFS,
        FPB_ATQ_OFS, FPB_ATS_OFS, FPB_ARQ_OFS};
    localparam logic [4:0][31:0] FPB_RST = {FPB_ITX_RST, FPB_IRX_RST,
        FPB_ATQ_RST, FPB_ATS_RST, FPB_ARQ_RST};
    typedef logic [5:0] fpb_blk_t;
endpackage
`default_nettype wire

// file: hdl/fpb_size_regs.sv
`timescale 1ns/1ns
`default_nettype none
module fpb_size_regs
    import fpb_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [FPB_HOST_AW-1:0] host_addr_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [31:0] host_wdata_in,
    output logic [31:0] host_rdata_out,
    output logic host_rvalid_out,
    output logic [FPB_PTR_W-1:0] ptr_out,
    output logic [FPB_NUM_FIFOS-1:0][11:0] start_addr_out,
    output logic [FPB_NUM_FIFOS-1:0][11:0] end_addr_out,
    output logic [FPB_NUM_FIFOS-1:0][12:0] capacity_out
);
    logic [FPB_PTR_W-1:0] ptr_ff;
    logic [FPB_PTR_W-1:0] nxt_ptr;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic ptr_wr;
    logic data_acc;
    logic data_wr;
    logic [FPB_NUM_FIFOS-1:0] hit;
    fpb_blk_t start_ff [FPB_NUM_FIFOS];
    fpb_blk_t end_ff [FPB_NUM_FIFOS];
    logic [31:0] sel_word;

    // The host port runs on this clock, so its strobes are used directly.
    // Each high cycle of a strobe is one access; there are no wait states.
    assign ptr_wr = host_wr_in && (host_addr_in == FPB_PTR_OFS);
    assign data_wr = host_wr_in && (host_addr_in == FPB_DATA_OFS);
    assign data_acc = (host_wr_in || host_rd_in) && (host_addr_in == FPB_DATA_OFS);

    // A pointer load wins over a data access in the same cycle, since software
    // intends the freshly loaded address to be the next one used.
    always_comb begin
        nxt_ptr = ptr_ff;
        if (ptr_wr) begin
            nxt_ptr = host_wdata_in[FPB_PTR_W-1:0];
        end else if (data_acc) begin
            nxt_ptr = ptr_ff + FPB_QUAD_STEP;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ptr_ff <= 16'h0000;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // Unmapped indirect addresses read as zero.
    always_comb begin
        sel_word = 32'h00000000;
        for (int i = 0; i < FPB_NUM_FIFOS; i++) begin
            if (hit[i]) begin
                sel_word = {18'h00000, start_ff[i], 2'b00, end_ff[i]};
            end
        end
    end

    // Reads answer one cycle later from a register, which keeps the read mux
    // off the host's output path at the cost of one cycle of latency.
    always_comb begin
        nxt_rvalid = host_rd_in;
        nxt_rdata = rdata_ff;
        if (host_rd_in) begin
            case (host_addr_in)
                FPB_PTR_OFS: nxt_rdata = {16'h0000, ptr_ff};
                FPB_DATA_OFS: nxt_rdata = sel_word;
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_ff <= 32'h00000000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign host_rdata_out = rdata_ff;
    assign host_rvalid_out = rvalid_ff;
    assign ptr_out = ptr_ff;

    // One slice per FIFO: its two fields, the derived bounds and the capacity.
    genvar g;
    generate
        for (g = 0; g < FPB_NUM_FIFOS; g++) begin : gen_fifo
            fpb_blk_t nxt_start;
            fpb_blk_t nxt_end;
            logic [6:0] blocks;
            logic [12:0] cap_ff;
            logic [12:0] nxt_cap;

            assign hit[g] = (ptr_ff == FPB_OFS[g]);

            // Only the two fields are stored, so unused bits cannot be set.
            always_comb begin
                nxt_start = start_ff[g];
                nxt_end = end_ff[g];
                if (data_wr && hit[g]) begin
                    nxt_start = host_wdata_in[FPB_START_MSB:FPB_START_LSB];
                    nxt_end = host_wdata_in[FPB_END_MSB:FPB_END_LSB];
                end
            end

            // Capacity is registered so the subtract and add stay off the FIFO logic.
            // Inverted ranges simply wrap; keeping them sane is up to software.
            always_comb begin
                blocks = {1'b0, end_ff[g]} - {1'b0, start_ff[g]} + FPB_ONE_BLOCK;
                nxt_cap = {blocks, FPB_LOW_ZEROS};
            end

            always_ff @(posedge sys_clk_in) begin
                if (rst_in) begin
                    start_ff[g] <= FPB_RST[g][FPB_START_MSB:FPB_START_LSB];
                    end_ff[g] <= FPB_RST[g][FPB_END_MSB:FPB_END_LSB];
                    cap_ff <= 13'h0000;
                end else begin
                    start_ff[g] <= nxt_start;
                    end_ff[g] <= nxt_end;
                    cap_ff <= nxt_cap;
                end
            end

            // Bounds are live: a new partition is seen by the address
            // generators at once, so software should change it only while
            // the FIFO is held in reset.
            assign start_addr_out[g] = {start_ff[g], FPB_LOW_ZEROS};
            assign end_addr_out[g] = {end_ff[g], FPB_LOW_ONES};
            assign capacity_out[g] = cap_ff;

            sequence s_field_wr;
                data_wr && hit[g];
            endsequence

            chk_start_field: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                s_field_wr |=> start_ff[g] == $past(host_wdata_in[13:8]))
                else $error("start block not stored");

            chk_end_field: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                s_field_wr |=> end_ff[g] == $past(host_wdata_in[5:0]))
                else $error("end block not stored");

            chk_reset_bounds: assert property (
                @(posedge sys_clk_in)
                $past(rst_in) && !rst_in |-> {18'h00000, start_ff[g], 2'b00, end_ff[g]} == FPB_RST[g])
                else $error("bounds reset value wrong");

            chk_capacity_calc: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                $stable(start_ff[g]) && $stable(end_ff[g]) |=>
                capacity_out[g] == 13'((7'($past(end_ff[g]) - $past(start_ff[g])) + 7'd1) * 64))
                else $error("capacity mismatch");

            chk_addr_form: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                start_addr_out[g][5:0] == 6'h00 && end_addr_out[g][5:0] == 6'h3F &&
                start_addr_out[g][11:6] == start_ff[g] && end_addr_out[g][11:6] == end_ff[g])
                else $error("address bound layout wrong");

            chk_live_bounds: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                s_field_wr |=> start_addr_out[g] == {$past(host_wdata_in[13:8]), 6'h00})
                else $error("bounds did not follow write");

            sequence s_field_rd;
                host_rd_in && host_addr_in == FPB_DATA_OFS && hit[g];
            endsequence

            // A data port read must show exactly this register's two fields.
            chk_read_word: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                s_field_rd |=> host_rdata_out == {18'h00000, $past(start_ff[g]), 2'b00, $past(end_ff[g])})
                else $error("register word read back wrong");

            // Any cycle without a write to this register leaves both fields alone.
            chk_field_hold: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                !(data_wr && hit[g]) |=> $stable(start_ff[g]) && $stable(end_ff[g]))
                else $error("bounds changed without a write");

            // The end bound follows a write on the very next cycle, like the start bound.
            chk_end_live: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                s_field_wr |=> end_addr_out[g] == {$past(host_wdata_in[5:0]), 6'h3F})
                else $error("end bound did not follow write");

            // Regions are whole 64-quadlet blocks, so the low six capacity bits stay clear.
            chk_cap_granule: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                capacity_out[g][5:0] == 6'h00)
                else $error("capacity not whole blocks");

            // The capacity register is cleared by reset, so it reads zero for one
            // cycle after release before the first recomputation lands.
            chk_cap_reset: assert property (
                @(posedge sys_clk_in)
                $past(rst_in) && !rst_in |-> capacity_out[g] == 13'h0000)
                else $error("capacity not cleared by reset");
        end
    endgenerate

    // Host port checks. The strobes come from logic on this clock, so every
    // property samples them on the same edge as the registers.
    sequence s_data_rd;
        host_rd_in && host_addr_in == FPB_DATA_OFS;
    endsequence

    sequence s_any_wr_then_rd;
        data_wr ##1 s_data_rd;
    endsequence

    chk_unused_zero: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        s_data_rd |=> host_rdata_out[31:14] == 18'h00000 && host_rdata_out[7:6] == 2'b00)
        else $error("unused bits not zero");

    chk_write_mask: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        s_any_wr_then_rd |=> host_rvalid_out && host_rdata_out[31:14] == 18'h00000 &&
        host_rdata_out[7:6] == 2'b00)
        else $error("unused bits took a write");

    chk_ptr_advance: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        data_acc && !ptr_wr |=> ptr_ff == 16'($past(ptr_ff) + 16'h0004))
        else $error("pointer did not advance");

    chk_ptr_load: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ptr_wr |=> ptr_ff == $past(host_wdata_in[15:0]) ##1 (ptr_ff == $past(ptr_ff) || $past(data_acc || ptr_wr)))
        else $error("pointer load wrong");

    chk_read_latency: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        host_rd_in |=> host_rvalid_out)
        else $error("read answer missing");

    // The read answer is high for one cycle per cycle of read strobe, and only a read can cause it.
    chk_rvalid_pulse: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !host_rd_in |=> !host_rvalid_out)
        else $error("read answer without a read");

    // Read data is held between reads so a slow host can still pick it up.
    chk_rdata_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !host_rd_in |=> $stable(host_rdata_out))
        else $error("read data changed without a read");

    // Only a pointer load or a data port access may move the pointer.
    chk_ptr_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !data_acc && !ptr_wr |=> $stable(ptr_ff))
        else $error("pointer moved without an access");

    // Reading the pointer returns it as it stood, without advancing it.
    chk_ptr_readback: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        host_rd_in && host_addr_in == FPB_PTR_OFS |=> host_rdata_out == {16'h0000, $past(ptr_ff)})
        else $error("pointer read back wrong");

    // Offsets outside the two host registers are refused: reads give zero.
    chk_unmapped_host: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        host_rd_in && host_addr_in != FPB_PTR_OFS && host_addr_in != FPB_DATA_OFS |=>
        host_rdata_out == 32'h00000000)
        else $error("unmapped host read not zero");

    // An indirect address that names no size register reads as zero.
    chk_unmapped_data: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        host_rd_in && host_addr_in == FPB_DATA_OFS && hit == '0 |=> host_rdata_out == 32'h00000000)
        else $error("unmapped indirect read not zero");

    // The size registers sit at distinct offsets, so at most one can match.
    chk_one_hit: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $onehot0(hit))
        else $error("two size registers share an offset");

    // Reset returns the host port to a known idle state.
    chk_ptr_reset: assert property (
        @(posedge sys_clk_in)
        $past(rst_in) && !rst_in |-> ptr_ff == 16'h0000 && !host_rvalid_out && host_rdata_out == 32'h00000000)
        else $error("host port not cleared by reset");

    // Writes are posted: they never produce a read answer.
    chk_wr_no_answer: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        host_wr_in && !host_rd_in |=> !host_rvalid_out)
        else $error("write produced a read answer");
endmodule
`default_nettype wire

// file: dv/fifo_partition_size_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_partition_size_regs_tb;
    import fpb_pkg::*;
    localparam logic [4:0][15:0] OFS = {16'h0130, 16'h0120, 16'h0114, 16'h0110, 16'h0104};
    localparam logic [4:0][31:0] RST = {32'h0000202F, 32'h0000101F, 32'h00000C0F, 32'h0000080B, 32'h00000407};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic rvalid;
    logic [15:0] ptr;
    logic [4:0][11:0] st_a;
    logic [4:0][11:0] en_a;
    logic [4:0][12:0] cap;
    logic [31:0] got;
    logic [5:0] s;
    logic [5:0] e;
    int n_fail = 0;
    int compares = 0;
    always #4 sys_clk = ~sys_clk;
    fpb_size_regs dut_u (.sys_clk_in(sys_clk), .rst_in(rst), .host_addr_in(addr), .host_wr_in(wr),
        .host_rd_in(rd), .host_wdata_in(wdata), .host_rdata_out(rdata), .host_rvalid_out(rvalid),
        .ptr_out(ptr), .start_addr_out(st_a), .end_addr_out(en_a), .capacity_out(cap));
    task automatic stop_test;
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string what);
        compares++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, g, x);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask
    // The answer is expected one edge after the strobe; a few spare edges guard against a hang.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        n = 0;
        while (rvalid !== 1'b1) begin
            if (n == 3) begin
                n_fail++;
                $display("unexpected at %0t: no read answer", $time);
                stop_test();
            end
            n++;
            @(posedge sys_clk);
            #1;
        end
        d = rdata;
    endtask
    // Capacity is registered, so one extra edge is allowed before it is looked at.
    task automatic chk_bounds(input int i, input logic [5:0] bs, input logic [5:0] be);
        @(posedge sys_clk);
        #1;
        chk({20'h00000, st_a[i]}, {20'h00000, bs, 6'h00}, "start address");
        chk({20'h00000, en_a[i]}, {20'h00000, be, 6'h3F}, "end address");
        chk({19'h00000, cap[i]}, 32'((int'(be) - int'(bs) + 1) * 64), "capacity");
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        chk({16'h0000, ptr}, 32'h00000000, "pointer after reset");
        for (int i = 0; i < 5; i++) begin
            wr_reg(FPB_PTR_OFS, {16'h0000, OFS[i]});
            rd_reg(FPB_DATA_OFS, got);
            chk(got, RST[i], "reset value");
            chk({16'h0000, ptr}, {16'h0000, OFS[i] + 16'h0004}, "pointer step");
            chk_bounds(i, RST[i][13:8], RST[i][5:0]);
        end
        $display("test reset_values done");
        for (int i = 0; i < 5; i++) begin
            s = 6'(i * 9 + 1);
            e = 6'(i * 9 + 8);
            wr_reg(FPB_PTR_OFS, {16'h0000, OFS[i]});
            wr_reg(FPB_DATA_OFS, 32'hFFFFC0C0 | {18'h00000, s, 2'b00, e});
            wr_reg(FPB_PTR_OFS, {16'h0000, OFS[i]});
            rd_reg(FPB_DATA_OFS, got);
            chk(got, {18'h00000, s, 2'b00, e}, "masked write");
            chk_bounds(i, s, e);
        end
        $display("test masked_writes done");
        wr_reg(FPB_PTR_OFS, {16'h0000, OFS[1]});
        wr_reg(FPB_DATA_OFS, 32'h00000A0C);
        wr_reg(FPB_DATA_OFS, 32'h00000D0E);
        chk({16'h0000, ptr}, 32'h00000118, "pointer after two writes");
        wr_reg(FPB_DATA_OFS, 32'h00003F3F);
        chk({16'h0000, ptr}, 32'h0000011C, "pointer past unmapped place");
        wr_reg(FPB_PTR_OFS, {16'h0000, OFS[1]});
        rd_reg(FPB_DATA_OFS, got);
        chk(got, 32'h00000A0C, "first streamed word");
        rd_reg(FPB_DATA_OFS, got);
        chk(got, 32'h00000D0E, "second streamed word");
        rd_reg(FPB_DATA_OFS, got);
        chk(got, 32'h00000000, "unmapped indirect read");
        chk_bounds(1, 6'h0A, 6'h0C);
        $display("test auto_increment done");
        rd_reg(8'h00, got);
        chk(got, 32'h00000000, "unmapped host read");
        wr_reg(8'h00, 32'h00000104);
        chk({16'h0000, ptr}, 32'h0000011C, "unmapped host write");
        $display("test unmapped_host done");
        wr_reg(FPB_PTR_OFS, {16'h0000, OFS[1]});
        @(posedge sys_clk);
        addr <= FPB_DATA_OFS;
        wdata <= 32'hFFFFC5C6;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk({31'h00000000, rvalid}, 32'h00000001, "answer to back to back read");
        chk(rdata, 32'h00000D0E, "read right after write");
        chk({16'h0000, ptr}, 32'h00000118, "pointer after write and read");
        rd_reg(FPB_PTR_OFS, got);
        chk(got, 32'h00000118, "pointer read back");
        chk_bounds(1, 6'h05, 6'h06);
        $display("test write_then_read done");
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wr_reg(FPB_PTR_OFS, {16'h0000, OFS[3]});
        rd_reg(FPB_DATA_OFS, got);
        chk(got, RST[3], "value after second reset");
        chk_bounds(0, RST[0][13:8], RST[0][5:0]);
        $display("test second_reset done");
        stop_test();
    end
endmodule
`default_nettype wire
